// ### hw/mem_integrity_params.svh
`ifndef MEM_INTEGRITY_PARAMS_SVH
`define MEM_INTEGRITY_PARAMS_SVH

// ****************************************
// register offsets
// ****************************************
`define OFF_PROGRAM_ECC_CONFIG 16'hA00D
`define OFF_PROGRAM_FAULT_ADDR_LOW 16'hA00E
`define OFF_PROGRAM_FAULT_ADDR_HIGH 16'hA00F
`define OFF_SELF_TEST_COMMAND 16'hA016
`define OFF_DATA_ECC_STATUS 16'hA02D
`define OFF_DATA_FAULT_ADDR_LOW 16'hA02E
`define OFF_DATA_FAULT_ADDR_HIGH 16'hA02F

// ****************************************
// field positions
// ****************************************
`define BIT_PROG_UNCORR_IRQ_EN 5
`define BIT_PROG_CORR_IRQ_EN 4
`define BIT_PROG_UNCORR_FLAG 1
`define BIT_PROG_CORR_FLAG 0
`define BIT_DATA_ECC_FLAG 1
`define BIT_ST_BUSY 3
`define BIT_ST_FAIL 1
`define BIT_ST_FINISH 0

// ****************************************
// reset values
// ****************************************
`define RST_PROGRAM_ECC_CONFIG 8'h80
`define RST_ADDR 16'h0000
`define RST_MODE 4'h0

// ****************************************
// self-test command and mode codes
// ****************************************
`define CMD_CLEAR 4'h0
`define CMD_START 4'h5
`define CMD_START_RESET 4'hA
`define MODE_NORMAL_A 4'h0
`define MODE_NORMAL_B 4'h8
`define MODE_MBIST 4'h1
`define MODE_MBIST_MON 4'h9
`define MODE_LBIST_MON 4'hC

`endif

// ### hw/mem_integrity_pkg.sv
package mem_integrity_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } bist_state_t;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [15:0] word;
  } fetch_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] code;
  } fetch_rsp_t;

  typedef struct packed {
    logic err;
    logic [15:0] addr;
  } data_fault_t;

  typedef struct packed {
    logic start;
    logic abort;
    logic mbist;
    logic lbist;
    logic monitor;
  } bist_ctl_t;

endpackage

// ### hw/memory_ecc_fault_and_bist_control.sv
`timescale 1ns/1ps
`include "mem_integrity_params.svh"
// Summary of operation
// [RL1] data SRAM fault address captured, read-only
// [RL2] held while data error flag set
// [RL3] flash low byte code, high byte check
// [RL4] bits 15-12 guard 7-4, 11-8 guard 3-0
// [RL5] per nibble: correct one, detect two
// [RL6] corrected code delivered, correctable interrupt
// [RL7] uncorrectable: interrupt or software reset
// [RL8] reset enable bit selects reset path
// [RL9] any fetch error latches program address
// [RL10] program fault address read-only, latest error
// [RL11] flags set always, software writes to clear
// [RL12] data uncorrectable error latches address, interrupts
// [RL13] mode decode: normal, MBIST, monitored variants
// [RL14] mode cleared only by hardware reset
// [RL15] busy reads one during test
// [RL16] fail set on error, cleared by command
// [RL17] finish set on completion, cleared by command
// [RL18] command 0101 starts selected test
// [RL19] command 1010 starts test, then resets
// [RL20] command 0000 clears fail and finish
// [RL21] other commands abort running test
// [RL22] CPU stalled until test completes
// [RL23] after test, CPU/SRAM state undefined
// [RL24] software reset keeps mode, fail, finish

module memory_ecc_fault_and_bist_control
  import mem_integrity_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sw_rst,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire fetch_req_t fetch_req,
  output fetch_rsp_t fetch_rsp,
  input wire data_fault_t data_fault,
  input wire logic fetch_ecc_reset_enable,
  input wire logic bist_done,
  input wire logic bist_error,
  output bist_ctl_t bist_ctl,
  output logic cpu_stall,
  output logic prog_correctable_irq,
  output logic prog_uncorrectable_irq,
  output logic data_ecc_irq,
  output logic ecc_reset_req,
  output logic self_test_reset_req
);

  // ****************************************
  // register decode
  // ****************************************
  wire sel_pcfg = (reg_addr == `OFF_PROGRAM_ECC_CONFIG);
  wire sel_padl = (reg_addr == `OFF_PROGRAM_FAULT_ADDR_LOW);
  wire sel_padh = (reg_addr == `OFF_PROGRAM_FAULT_ADDR_HIGH);
  wire sel_stc = (reg_addr == `OFF_SELF_TEST_COMMAND);
  wire sel_dst = (reg_addr == `OFF_DATA_ECC_STATUS);
  wire sel_dadl = (reg_addr == `OFF_DATA_FAULT_ADDR_LOW);
  wire sel_dadh = (reg_addr == `OFF_DATA_FAULT_ADDR_HIGH);

  wire wr_pcfg = reg_wr & sel_pcfg;
  wire wr_stc = reg_wr & sel_stc;
  wire wr_dst = reg_wr & sel_dst;

  // ****************************************
  // state
  // ****************************************
  logic prog_correctable_irq_enable;
  logic prog_uncorrectable_irq_enable;
  logic prog_correctable_flag;
  logic prog_uncorrectable_flag;
  logic [15:0] program_fault_address;
  logic data_ecc_error_flag;
  logic [15:0] data_fault_address;
  logic [3:0] mode;
  logic fail;
  logic finish;
  logic auto_reset;
  bist_state_t state;

  // ****************************************
  // program fetch ECC, one checker per nibble
  // ****************************************
  wire [7:0] code_raw = fetch_req.word[7:0]; // RL3
  wire [7:0] check_raw = fetch_req.word[15:8]; // RL3
  logic [7:0] code_fixed;
  logic [1:0] nib_corr;
  logic [1:0] nib_uncorr;

  // check nibble: [0] covers d0,d1,d3; [1] d0,d2,d3; [2] d1,d2,d3; [3] overall parity
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_nib
      wire [3:0] d = code_raw[gi*4 +: 4]; // RL4
      wire [3:0] c = check_raw[gi*4 +: 4]; // RL4
      wire s0 = c[0] ^ d[0] ^ d[1] ^ d[3];
      wire s1 = c[1] ^ d[0] ^ d[2] ^ d[3];
      wire s2 = c[2] ^ d[1] ^ d[2] ^ d[3];
      wire [2:0] syn = {s2, s1, s0};
      wire par = ^{d, c};
      // odd overall parity means one flipped bit; even parity with a syndrome means two
      wire single = par; // RL5
      wire double = ~par & (syn != 3'b000); // RL5
      wire [3:0] flip = {
        single & (syn == 3'd7),
        single & (syn == 3'd6),
        single & (syn == 3'd5),
        single & (syn == 3'd3)
      };
      assign code_fixed[gi*4 +: 4] = d ^ flip; // RL5
      assign nib_corr[gi] = single;
      assign nib_uncorr[gi] = double;
    end
  endgenerate

  wire fetch_corr = fetch_req.valid & (|nib_corr) & ~(|nib_uncorr);
  wire fetch_uncorr = fetch_req.valid & (|nib_uncorr);
  wire fetch_err = fetch_corr | fetch_uncorr;

  // ****************************************
  // program ECC flags and enables
  // ****************************************
  wire clr_pcorr = wr_pcfg & reg_wdata[`BIT_PROG_CORR_FLAG];
  wire clr_puncorr = wr_pcfg & reg_wdata[`BIT_PROG_UNCORR_FLAG];
  // a detection in the clearing cycle wins so no event is lost
  wire next_prog_correctable_flag = fetch_corr | (prog_correctable_flag & ~clr_pcorr); // RL11
  wire next_prog_uncorrectable_flag =
    fetch_uncorr | (prog_uncorrectable_flag & ~clr_puncorr); // RL11

  always_ff @(posedge clk_sys) begin
    if (rst || sw_rst) begin
      prog_correctable_irq_enable <= 1'b0;
      prog_uncorrectable_irq_enable <= 1'b0;
    end else if (wr_pcfg) begin
      prog_correctable_irq_enable <= reg_wdata[`BIT_PROG_CORR_IRQ_EN];
      prog_uncorrectable_irq_enable <= reg_wdata[`BIT_PROG_UNCORR_IRQ_EN];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || sw_rst) begin
      prog_correctable_flag <= 1'b0;
      prog_uncorrectable_flag <= 1'b0;
    end else begin
      prog_correctable_flag <= next_prog_correctable_flag;
      prog_uncorrectable_flag <= next_prog_uncorrectable_flag;
    end
  end

  // latest faulting fetch address, software cannot write it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      program_fault_address <= `RST_ADDR;
    end else if (fetch_err) begin
      program_fault_address <= fetch_req.addr; // RL9 RL10
    end
  end

  // corrected code goes out one cycle after the fetch
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fetch_rsp <= '0;
    end else begin
      fetch_rsp.valid <= fetch_req.valid;
      fetch_rsp.code <= code_fixed; // RL6
    end
  end

  // ****************************************
  // program ECC interrupts and reset request
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (rst || sw_rst) begin
      prog_correctable_irq <= 1'b0;
    end else begin
      prog_correctable_irq <= prog_correctable_flag & prog_correctable_irq_enable; // RL6
    end
  end

  // with the reset path chosen the interrupt stays quiet
  always_ff @(posedge clk_sys) begin
    if (rst || sw_rst) begin
      prog_uncorrectable_irq <= 1'b0;
    end else begin
      prog_uncorrectable_irq <= prog_uncorrectable_flag & prog_uncorrectable_irq_enable
                                & ~fetch_ecc_reset_enable; // RL7
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || sw_rst) begin
      ecc_reset_req <= 1'b0;
    end else begin
      ecc_reset_req <= fetch_uncorr & fetch_ecc_reset_enable; // RL7 RL8
    end
  end

  // ****************************************
  // data SRAM fault capture
  // ****************************************
  wire clr_dflag = wr_dst & reg_wdata[`BIT_DATA_ECC_FLAG];
  wire next_data_ecc_error_flag = data_fault.err | (data_ecc_error_flag & ~clr_dflag); // RL12
  wire capture_daddr = data_fault.err & ~data_ecc_error_flag; // RL2

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      data_ecc_error_flag <= 1'b0;
    end else begin
      data_ecc_error_flag <= next_data_ecc_error_flag;
    end
  end

  // only the first fault after a clear is kept, later ones would hide its cause
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      data_fault_address <= `RST_ADDR;
    end else if (capture_daddr) begin
      data_fault_address <= data_fault.addr; // RL1
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      data_ecc_irq <= 1'b0;
    end else begin
      data_ecc_irq <= data_ecc_error_flag; // RL12
    end
  end

  // ****************************************
  // self-test command decode
  // ****************************************
  wire [3:0] cmd_code = reg_wdata[3:0];
  wire [3:0] mode_wr = reg_wdata[7:4];
  wire cmd_start = wr_stc & (cmd_code == `CMD_START); // RL18
  wire cmd_start_rst = wr_stc & (cmd_code == `CMD_START_RESET); // RL19
  wire cmd_clear = wr_stc & (cmd_code == `CMD_CLEAR); // RL20
  wire cmd_other = wr_stc & ~cmd_start & ~cmd_start_rst & ~cmd_clear;
  wire busy = (state == ST_RUN);

  // a start picks its test from the mode value written with it
  wire [3:0] eff_mode = busy ? mode : mode_wr;
  wire is_mbist = (eff_mode == `MODE_MBIST) | (eff_mode == `MODE_MBIST_MON); // RL13
  wire is_lbist = (eff_mode == `MODE_LBIST_MON); // RL13
  wire is_mon = (eff_mode == `MODE_MBIST_MON) | (eff_mode == `MODE_LBIST_MON); // RL13
  // normal and reserved modes run nothing; the command only clears the flags and stores the mode
  wire go = (cmd_start | cmd_start_rst) & ~busy & (is_mbist | is_lbist);
  wire abort = cmd_other & busy; // RL21
  wire done_now = busy & bist_done;

  // ****************************************
  // self-test sequencing
  // ****************************************
  bist_state_t next_state;
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (go) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (abort || bist_done) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // a software reset cannot land mid-test since the CPU is stalled, but it aborts anyway
  always_ff @(posedge clk_sys) begin
    if (rst || sw_rst) begin
      state <= ST_IDLE;
      auto_reset <= 1'b0;
    end else begin
      state <= next_state;
      if (go) begin
        auto_reset <= cmd_start_rst;
      end
    end
  end

  // mode survives software resets so the result stays readable
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode <= `RST_MODE; // RL14
    end else if (wr_stc && !busy) begin
      mode <= mode_wr; // RL24
    end
  end

  wire any_cmd = cmd_start | cmd_start_rst | cmd_clear; // RL16 RL17
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fail <= 1'b0;
      finish <= 1'b0;
    end else begin
      // result flags ignore sw_rst so the auto reset keeps them
      if (done_now) begin
        fail <= bist_error; // RL16 RL24
        finish <= 1'b1; // RL17 RL24
      end else if (any_cmd && !busy) begin
        fail <= 1'b0; // RL16 RL20
        finish <= 1'b0; // RL17 RL20
      end
    end
  end

  // ****************************************
  // self-test outputs
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (rst || sw_rst) begin
      bist_ctl <= '0;
    end else begin
      bist_ctl.start <= go; // RL18 RL19
      bist_ctl.abort <= abort; // RL21
      if (go) begin
        bist_ctl.mbist <= is_mbist;
        bist_ctl.lbist <= is_lbist;
        bist_ctl.monitor <= is_mon;
      end
    end
  end

  // CPU state is undefined after a test; the stall covers the whole run
  always_ff @(posedge clk_sys) begin
    if (rst || sw_rst) begin
      cpu_stall <= 1'b0;
    end else begin
      cpu_stall <= (next_state == ST_RUN); // RL15 RL22 RL23
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || sw_rst) begin
      self_test_reset_req <= 1'b0;
    end else begin
      self_test_reset_req <= done_now & auto_reset; // RL19 RL23
    end
  end

  // ****************************************
  // read path
  // ****************************************
  wire [7:0] rd_pcfg = {1'b1, 1'b0, prog_uncorrectable_irq_enable,
                        prog_correctable_irq_enable, 2'b00,
                        prog_uncorrectable_flag, prog_correctable_flag};
  wire [7:0] rd_stc = {mode, busy, 1'b0, fail, finish}; // RL15
  wire [7:0] rd_dst = {6'b000000, data_ecc_error_flag, 1'b0};
  wire [7:0] rd_mux =
    sel_pcfg ? rd_pcfg :
    sel_padl ? program_fault_address[7:0] :
    sel_padh ? program_fault_address[15:8] :
    sel_stc ? rd_stc :
    sel_dst ? rd_dst :
    sel_dadl ? data_fault_address[7:0] :
    sel_dadh ? data_fault_address[15:8] :
    8'h00;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

endmodule // memory_ecc_fault_and_bist_control

// ### verif/mem_integrity_assertions.sv
`timescale 1ns/1ps
`include "mem_integrity_params.svh"
module mem_integrity_assertions
  import mem_integrity_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire fetch_req_t fetch_req,
  input wire fetch_rsp_t fetch_rsp,
  input wire data_fault_t data_fault,
  input wire logic fetch_ecc_reset_enable,
  input wire logic bist_done,
  input wire bist_ctl_t bist_ctl,
  input wire logic cpu_stall,
  input wire logic data_ecc_irq,
  input wire logic ecc_reset_req,
  input wire logic self_test_reset_req
);
  function automatic logic [3:0] enc4(input logic [3:0] d);
    logic [2:0] c;
    c = {d[1]^d[2]^d[3], d[0]^d[2]^d[3], d[0]^d[1]^d[3]};
    return {^{d, c}, c};
  endfunction
  // even error count with a nonzero syndrome means two flipped bits
  function automatic logic dbl(input logic [3:0] d, input logic [3:0] c);
    return (c != enc4(d)) && !(^{d, c});
  endfunction
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ****************************************
  // assertions
  // ****************************************
  chk_fetch_answer: assert property (fetch_req.valid |=> fetch_rsp.valid)
    else $error("fetch answer missing");
  chk_fetch_clean: assert property (fetch_req.valid && fetch_req.word[15:8] ==
    {enc4(fetch_req.word[7:4]), enc4(fetch_req.word[3:0])}
    |=> fetch_rsp.code == $past(fetch_req.word[7:0])) else $error("clean code altered");
  chk_ecc_reset: assert property (fetch_req.valid && fetch_ecc_reset_enable &&
    dbl(fetch_req.word[3:0], fetch_req.word[11:8]) |-> ##[1:2] ecc_reset_req)
    else $error("no ecc reset");
  chk_data_irq: assert property (data_fault.err |-> ##[1:2] data_ecc_irq)
    else $error("no data irq");
  chk_start_cause: assert property (bist_ctl.start |-> $past(reg_wr) &&
    $past(reg_addr) == `OFF_SELF_TEST_COMMAND &&
    $past(reg_wdata[3:0]) inside {`CMD_START, `CMD_START_RESET}) else $error("bad start");
  chk_start_select: assert property (bist_ctl.start |->
    bist_ctl.lbist == ($past(reg_wdata[7:4]) == `MODE_LBIST_MON) &&
    bist_ctl.monitor == $past(reg_wdata[7])) else $error("bad test select");
  chk_stall_start: assert property (bist_ctl.start |-> cpu_stall)
    else $error("cpu not stalled");
  chk_stall_end: assert property (cpu_stall && bist_done |=> !cpu_stall)
    else $error("stall held after done");
  chk_test_reset: assert property (self_test_reset_req |-> $past(bist_done) &&
    $past(cpu_stall)) else $error("stray test reset");
  cover property (bist_ctl.start);
  cover property (bist_ctl.abort);
  cover property (self_test_reset_req);
  cover property (ecc_reset_req);
endmodule // mem_integrity_assertions

// ### verif/memory_ecc_fault_and_bist_control_test.sv
`timescale 1ns/1ps
`include "mem_integrity_params.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; \
  $display("mismatch at %0t: got %h expected %h", $time, a, e); end end
module memory_ecc_fault_and_bist_control_test
  import mem_integrity_pkg::*;
;
  logic clk_sys = 0, rst = 1, sw_rst = 0, reg_wr = 0, reg_rd = 0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, d;
  fetch_req_t fetch_req = '0;
  fetch_rsp_t fetch_rsp;
  data_fault_t data_fault = '0;
  logic fetch_ecc_reset_enable = 0, bist_done = 0, bist_error = 0, seen;
  bist_ctl_t bist_ctl;
  logic cpu_stall, prog_correctable_irq, prog_uncorrectable_irq, data_ecc_irq;
  logic ecc_reset_req, self_test_reset_req;
  logic [15:0] a, last = 16'h0000;
  int checked = 0, n_fail = 0;
  typedef struct packed {logic [15:0] flip; logic [1:0] kind;} row_t;
  // kind: 0 clean, 1 correctable, 2 uncorrectable
  row_t rows [6] = '{'{16'h0000, 2'd0}, '{16'h0001, 2'd1}, '{16'h0080, 2'd1},
    '{16'h0100, 2'd1}, '{16'h0810, 2'd1}, '{16'h0003, 2'd2}};
  memory_ecc_fault_and_bist_control memory_ecc_fault_and_bist_control_i (.*);
  always #25 clk_sys = ~clk_sys;
  function automatic logic [15:0] enc(input logic [7:0] v);
    logic [2:0] h, l;
    h = {v[5]^v[6]^v[7], v[4]^v[6]^v[7], v[4]^v[5]^v[7]};
    l = {v[1]^v[2]^v[3], v[0]^v[2]^v[3], v[0]^v[1]^v[3]};
    return {^{v[7:4], h}, h, ^{v[3:0], l}, l, v};
  endfunction
  task automatic wr(input logic [15:0] ad, input logic [7:0] v);
    @(posedge clk_sys); reg_addr <= ad; reg_wdata <= v; reg_wr <= 1;
    @(posedge clk_sys); reg_wr <= 0; #1;
  endtask
  task automatic rd(input logic [15:0] ad, input logic [7:0] e);
    @(posedge clk_sys); reg_addr <= ad; reg_rd <= 1;
    @(posedge clk_sys); reg_rd <= 0; #1;
    `CHK(reg_rdata, e)
  endtask
  task automatic fetch(input logic [15:0] ad, input logic [15:0] w);
    @(posedge clk_sys); fetch_req <= '{1'b1, ad, w};
    @(posedge clk_sys); fetch_req.valid <= 0; #1;
  endtask
  task automatic bdone(input logic e);
    @(posedge clk_sys); bist_done <= 1; bist_error <= e;
    @(posedge clk_sys); bist_done <= 0; #1;
  endtask
  task automatic fault(input logic [15:0] ad);
    @(posedge clk_sys); data_fault <= '{1'b1, ad};
    @(posedge clk_sys); data_fault.err <= 0; #1;
  endtask
  task automatic summarize;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #(50 * 5000);
    n_fail++;
    summarize;
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 0;
    rd(16'hA00D, 8'h80);
    rd(16'hA016, 8'h00);
    rd(16'hA000, 8'h00);
    $display("test reset values done");
    // ****************************************
    // fetch table
    // ****************************************
    wr(16'hA00D, 8'h30);
    for (int i = 0; i < 6; i++) begin
      d = 8'h3C + 8'(i * 17);
      a = 16'h1200 + 16'(i);
      fetch(a, enc(d) ^ rows[i].flip);
      `CHK(fetch_rsp.valid, 1'b1)
      if (rows[i].kind != 2'd2) `CHK(fetch_rsp.code, d)
      @(posedge clk_sys); #1;
      `CHK(prog_correctable_irq, rows[i].kind == 2'd1)
      `CHK(prog_uncorrectable_irq, rows[i].kind == 2'd2)
      if (rows[i].kind != 2'd0) last = a;
      rd(16'hA00D, {6'b101100, rows[i].kind == 2'd2, rows[i].kind == 2'd1});
      wr(16'hA00E, 8'hFF);
      rd(16'hA00E, last[7:0]);
      rd(16'hA00F, last[15:8]);
      wr(16'hA00D, 8'h33);
    end
    $display("test fetch table done");
    // ****************************************
    // data fault capture
    // ****************************************
    fault(16'h0123);
    fault(16'h0456);
    `CHK(data_ecc_irq, 1'b1)
    rd(16'hA02E, 8'h23);
    rd(16'hA02F, 8'h01);
    wr(16'hA02D, 8'h02);
    fault(16'h0456);
    rd(16'hA02E, 8'h56);
    $display("test data fault done");
    // ****************************************
    // self test
    // ****************************************
    wr(16'hA016, 8'h05);
    `CHK(cpu_stall, 1'b0)
    wr(16'hA016, 8'h15);
    `CHK(bist_ctl, 5'b10100)
    `CHK(cpu_stall, 1'b1)
    rd(16'hA016, 8'h18);
    bdone(1'b1);
    `CHK(cpu_stall, 1'b0)
    `CHK(self_test_reset_req, 1'b0)
    rd(16'hA016, 8'h13);
    @(posedge clk_sys); sw_rst <= 1;
    @(posedge clk_sys); sw_rst <= 0;
    rd(16'hA016, 8'h13);
    wr(16'hA016, 8'h10);
    rd(16'hA016, 8'h10);
    wr(16'hA016, 8'hCA);
    `CHK(bist_ctl, 5'b10011)
    bdone(1'b0);
    `CHK(self_test_reset_req, 1'b1)
    rd(16'hA016, 8'hC1);
    wr(16'hA016, 8'h95);
    rd(16'hA016, 8'h98);
    wr(16'hA016, 8'h93);
    `CHK(bist_ctl.abort, 1'b1)
    rd(16'hA016, 8'h90);
    `CHK(cpu_stall, 1'b0)
    @(posedge clk_sys); rst <= 1;
    @(posedge clk_sys); rst <= 0;
    rd(16'hA016, 8'h00);
    $display("test self test done");
    // ****************************************
    // uncorrectable fetch with reset enabled
    // ****************************************
    fetch_ecc_reset_enable <= 1;
    fetch(16'h2222, enc(8'h6B) ^ 16'h0030);
    seen = 0;
    repeat (3) begin
      if (ecc_reset_req === 1'b1) seen = 1;
      @(posedge clk_sys); #1;
    end
    `CHK(seen, 1'b1)
    rd(16'hA00F, 8'h22);
    $display("test ecc reset done");
    summarize;
  end
endmodule // memory_ecc_fault_and_bist_control_test
bind memory_ecc_fault_and_bist_control mem_integrity_assertions chk_i (
  .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .fetch_req(fetch_req), .fetch_rsp(fetch_rsp), .data_fault(data_fault),
  .fetch_ecc_reset_enable(fetch_ecc_reset_enable), .bist_done(bist_done),
  .bist_ctl(bist_ctl), .cpu_stall(cpu_stall), .data_ecc_irq(data_ecc_irq),
  .ecc_reset_req(ecc_reset_req), .self_test_reset_req(self_test_reset_req));
